// *** hdl/amd_pkg.sv ***
// Shared definitions of the operand addressing decoder: mode codes,
// prefix byte values, per-mode byte counts and the sequencer state.
// Assumes an 8-bit core with a 16-bit byte address space.
`default_nettype none

package amd_pkg;

  // ----------------------------------------------------------------
  // Widths and address limits
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [7:0] PAGE_ZERO_HI = 8'h00;
  localparam logic [15:0] ZERO_PAGE_TOP = 16'h00ff;
  localparam logic [15:0] IDX_SHORT_TOP = 16'h01fe;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam logic [1:0] CNT_STEP = 2'h1;
  localparam int REL_MIN = -128;
  localparam int REL_MAX = 127;

  // ----------------------------------------------------------------
  // Prefix bytes that reshape the following opcode
  // ----------------------------------------------------------------
  localparam logic [7:0] SECOND_INDEX_PREFIX_BYTE = 8'h90;
  localparam logic [7:0] INDIRECT_PREFIX_BYTE = 8'h92;
  localparam logic [7:0] INDIRECT_SECOND_INDEX_PREFIX = 8'h91;

  // ----------------------------------------------------------------
  // The seventeen operand addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    AM_INH = 5'h00,
    AM_IMM = 5'h01,
    AM_DIR_S = 5'h02,
    AM_DIR_L = 5'h03,
    AM_IDX_0 = 5'h04,
    AM_IDX_S = 5'h05,
    AM_IDX_L = 5'h06,
    AM_IND_S = 5'h07,
    AM_IND_L = 5'h08,
    AM_IIDX_S = 5'h09,
    AM_IIDX_L = 5'h0a,
    AM_REL_D = 5'h0b,
    AM_REL_I = 5'h0c,
    AM_BIT_D = 5'h0d,
    AM_BIT_I = 5'h0e,
    AM_BITREL_D = 5'h0f,
    AM_BITREL_I = 5'h10
  } amd_mode_t;

  // Sequencer states; every code is used.
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_OPND = 2'h1,
    ST_PTR = 2'h2,
    ST_CALC = 2'h3
  } amd_st_t;

  // Complete state of the decoder core.
  typedef struct packed {
    amd_st_t st;
    amd_mode_t mode;
    logic [7:0] idx;
    logic [15:0] pc;
    logic [15:0] addr;
    logic [1:0] cnt;
    logic [7:0] b1;
    logic [7:0] b2;
    logic [7:0] p1;
    logic [7:0] p2;
    logic done;
    logic err;
    logic [15:0] ea;
    logic [7:0] oper;
    logic [15:0] target;
    logic [2:0] len;
  } amd_state_t;

  localparam amd_state_t AMD_STATE_RST = '0;

  // Bytes fetched after the opcode, prefix not counted.
  function automatic logic [1:0] amd_opnd_bytes(amd_mode_t m);
    case (m)
      AM_INH, AM_IDX_0: amd_opnd_bytes = 2'h0;
      AM_DIR_L, AM_IDX_L, AM_BITREL_D, AM_BITREL_I: amd_opnd_bytes = 2'h2;
      default: amd_opnd_bytes = 2'h1;
    endcase
  endfunction

  // Bytes read through the in-memory pointer.
  function automatic logic [1:0] amd_ptr_bytes(amd_mode_t m);
    case (m)
      AM_IND_L, AM_IIDX_L: amd_ptr_bytes = 2'h2;
      AM_IND_S, AM_IIDX_S, AM_REL_I, AM_BIT_I, AM_BITREL_I:
        amd_ptr_bytes = 2'h1;
      default: amd_ptr_bytes = 2'h0;
    endcase
  endfunction

  // Long modes, which reach the whole 64 Kbyte space.
  function automatic logic amd_is_long(amd_mode_t m);
    amd_is_long = (m == AM_DIR_L) || (m == AM_IDX_L) ||
                  (m == AM_IND_L) || (m == AM_IIDX_L);
  endfunction

endpackage

`default_nettype wire

// *** hdl/amd_map_if.sv ***
// Carrier between the decoder core and its prefix mapper.
// Assumes both ends sit on the same core clock; it holds no state.
`timescale 1ns/100ps
`default_nettype none

interface amd_map_if;
  import amd_pkg::*;
  logic [7:0] prefix;
  amd_mode_t base_mode;
  amd_mode_t mode;
  logic use_y;
  logic prefix_seen;

  modport mapper(input prefix, input base_mode, output mode,
                 output use_y, output prefix_seen);
  modport core(output prefix, output base_mode, input mode,
               input use_y, input prefix_seen);
endinterface

`default_nettype wire

// *** hdl/amd_mode_map.sv ***
// Prefix mapper: turns the opcode's base mode and any prefix byte into
// the mode really used and the index register selected.
// Assumes a prefix value of any other code means no prefix.
`timescale 1ns/100ps
`default_nettype none

module amd_mode_map
  import amd_pkg::*;
(
  amd_map_if.mapper m
);

  // ----------------------------------------------------------------
  // Mode rewrite
  // ----------------------------------------------------------------
  // A prefix on an opcode it does not reshape leaves the mode alone;
  // such pairs are not trapped here.
  always_comb begin
    m.mode = m.base_mode;
    m.use_y = 1'b0;
    m.prefix_seen = 1'b0;
    if (m.prefix == SECOND_INDEX_PREFIX_BYTE) begin
      m.prefix_seen = 1'b1;
      m.use_y = 1'b1;
    end else if (m.prefix == INDIRECT_PREFIX_BYTE) begin
      m.prefix_seen = 1'b1;
      case (m.base_mode)
        AM_DIR_S: m.mode = AM_IND_S;
        AM_DIR_L: m.mode = AM_IND_L;
        AM_IDX_S: m.mode = AM_IIDX_S;
        AM_IDX_L: m.mode = AM_IIDX_L;
        AM_REL_D: m.mode = AM_REL_I;
        AM_BIT_D: m.mode = AM_BIT_I;
        AM_BITREL_D: m.mode = AM_BITREL_I;
        default: m.mode = m.base_mode;
      endcase
    end else if (m.prefix == INDIRECT_SECOND_INDEX_PREFIX) begin
      m.prefix_seen = 1'b1;
      m.use_y = 1'b1;
      case (m.base_mode)
        AM_IDX_S: m.mode = AM_IIDX_S;
        AM_IDX_L: m.mode = AM_IIDX_L;
        default: m.mode = m.base_mode;
      endcase
    end
  end

endmodule

`default_nettype wire

// *** hdl/amd_ea_add.sv ***
// Address adder: a 16-bit base plus an 8-bit offset, either zero or
// sign extended. Used for index sums and for branch targets.
// Assumes the caller wants the sum modulo 64 Kbyte.
`timescale 1ns/100ps
`default_nettype none

module amd_ea_add
  import amd_pkg::*;
#(
  parameter bit SIGN_EXT = 1'b0
)
(
  input wire logic [15:0] base_in,
  input wire logic [7:0] off_in,
  output logic [15:0] sum_out
);

  logic [15:0] ext;

  // Wrap at the top of the space is intended, as in the core's PC.
  assign ext = SIGN_EXT ? {{BYTE_W{off_in[BYTE_W-1]}}, off_in}
                        : {PAGE_ZERO_HI, off_in};
  assign sum_out = base_in + ext;

endmodule

`default_nettype wire

// *** hdl/amd_decoder.sv ***
// Operand addressing decoder of the 8-bit core. It takes a decoded
// base mode, prefix and PC, fetches the operand bytes and pointers,
// and returns the effective address, operand byte and branch target.
// Assumes memory on the core clock answering by a one-cycle ack.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - Seventeen addressing modes across seven groups are decoded.
// - Short submodes stay in zero page, except indexed up to 1FE, with fewer bytes and cycles.
// - Long submodes reach all 64 Kbyte at extra bytes and cycles.
// - Read-modify-write instructions accept short forms only.
// - Inherent instructions fetch nothing after the opcode.
// - Immediate takes one operand byte used as the value.
// - Short direct fetches one address byte, range 00 to FF.
// - Long direct fetches a two-byte word address.
// - Indexed address is unsigned sum of chosen index and offset.
// - No-offset indexed fetches nothing, uses the index alone.
// - No-offset indexed adds no byte with X, one with Y.
// - Short indexed offset byte gives addresses 00 to 1FE.
// - Long indexed fetches a word offset over the whole space.
// - Indirect byte addresses a memory pointer holding the operand address.
// - Short indirect uses a byte pointer, final address 00 to FF.
// - Long indirect uses a byte pointer address and word pointer.
// - Branch target is next PC plus signed displacement, -128 to +127.
// - Prefix 90 picks Y, 92 indirect, 91 indirect indexed with Y.
module amd_decoder
  import amd_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic dec_start_in,
  input wire amd_mode_t dec_mode_in,
  input wire logic [7:0] dec_prefix_in,
  input wire logic dec_rmw_in,
  input wire logic [15:0] dec_pc_in,
  input wire logic [7:0] idx_x_in,
  input wire logic [7:0] idx_y_in,
  input wire logic [7:0] mem_rdata_in,
  input wire logic mem_ack_in,
  output logic mem_req_out,
  output logic [15:0] mem_addr_out,
  output logic dec_busy_out,
  output logic dec_done_out,
  output logic dec_err_out,
  output amd_mode_t dec_mode_out,
  output logic [15:0] dec_ea_out,
  output logic [7:0] dec_operand_out,
  output logic [15:0] dec_target_out,
  output logic [15:0] dec_next_pc_out,
  output logic [2:0] dec_len_out
);

  // ----------------------------------------------------------------
  // Prefix mapping and address adders
  // ----------------------------------------------------------------
  amd_state_t r_reg;
  amd_state_t r_next;
  logic [15:0] idx_base;
  logic [15:0] idx_sum;
  logic [7:0] disp;
  logic [15:0] rel_sum;
  logic [7:0] b1_now;
  logic [1:0] cnt_inc;

  amd_map_if map ();

  // The mapper sees the request straight from the opcode decoder.
  assign map.prefix = dec_prefix_in;
  assign map.base_mode = dec_mode_in;

  amd_mode_map u_map (
    .m(map.mapper)
  );

  amd_ea_add #(.SIGN_EXT(1'b0)) u_idx_add (
    .base_in(idx_base),
    .off_in(r_reg.idx),
    .sum_out(idx_sum)
  );

  amd_ea_add #(.SIGN_EXT(1'b1)) u_rel_add (
    .base_in(r_reg.pc),
    .off_in(disp),
    .sum_out(rel_sum)
  );

  // Index adder base: the offset or pointer, widened as the mode asks.
  always_comb begin
    idx_base = '0;
    case (r_reg.mode)
      AM_IDX_S: idx_base = {PAGE_ZERO_HI, r_reg.b1};
      AM_IDX_L: idx_base = {r_reg.b1, r_reg.b2};
      AM_IIDX_S: idx_base = {PAGE_ZERO_HI, r_reg.p1};
      AM_IIDX_L: idx_base = {r_reg.p1, r_reg.p2};
      default: idx_base = '0;
    endcase
  end

  // Branch displacement source; zero keeps non-branch targets at PC.
  always_comb begin
    disp = '0;
    case (r_reg.mode)
      AM_REL_D: disp = r_reg.b1;
      AM_REL_I: disp = r_reg.p1;
      AM_BITREL_D, AM_BITREL_I: disp = r_reg.b2;
      default: disp = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Operand bytes come first from the PC, then pointer bytes from the
  // zero page address in the first operand byte. PC ends on the next
  // instruction, which is what relative branches are measured from.
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    b1_now = (r_reg.cnt == '0) ? mem_rdata_in : r_reg.b1;
    cnt_inc = r_reg.cnt + CNT_STEP;
    unique case (r_reg.st)
      ST_IDLE: begin
        if (dec_start_in) begin
          r_next.err = 1'b0;
          r_next.mode = map.mode;
          r_next.idx = map.use_y ? idx_y_in : idx_x_in;
          r_next.pc = dec_pc_in;
          r_next.addr = dec_pc_in;
          r_next.cnt = '0;
          r_next.b1 = '0;
          r_next.b2 = '0;
          r_next.p1 = '0;
          r_next.p2 = '0;
          // Length counts the prefix byte as well as the operands.
          r_next.len = {1'b0, amd_opnd_bytes(map.mode)} +
                       {2'b00, map.prefix_seen};
          if (dec_rmw_in && amd_is_long(map.mode)) begin
            r_next.err = 1'b1;
            r_next.done = 1'b1;
          end else if (amd_opnd_bytes(map.mode) == '0) begin
            r_next.st = ST_CALC;
          end else begin
            r_next.st = ST_OPND;
          end
        end
      end
      ST_OPND: begin
        if (mem_ack_in) begin
          if (r_reg.cnt == '0) begin
            r_next.b1 = mem_rdata_in;
          end else begin
            r_next.b2 = mem_rdata_in;
          end
          r_next.pc = r_reg.pc + ADDR_STEP;
          r_next.addr = r_reg.pc + ADDR_STEP;
          r_next.cnt = cnt_inc;
          if (cnt_inc == amd_opnd_bytes(r_reg.mode)) begin
            r_next.cnt = '0;
            if (amd_ptr_bytes(r_reg.mode) != '0) begin
              r_next.st = ST_PTR;
              r_next.addr = {PAGE_ZERO_HI, b1_now};
            end else begin
              r_next.st = ST_CALC;
            end
          end
        end
      end
      ST_PTR: begin
        if (mem_ack_in) begin
          if (r_reg.cnt == '0) begin
            r_next.p1 = mem_rdata_in;
          end else begin
            r_next.p2 = mem_rdata_in;
          end
          r_next.addr = r_reg.addr + ADDR_STEP;
          r_next.cnt = cnt_inc;
          if (cnt_inc == amd_ptr_bytes(r_reg.mode)) begin
            r_next.cnt = '0;
            r_next.st = ST_CALC;
          end
        end
      end
      ST_CALC: begin
        r_next.st = ST_IDLE;
        r_next.done = 1'b1;
        r_next.target = rel_sum;
        r_next.oper = (r_reg.mode == AM_IMM) ? r_reg.b1 : '0;
        case (r_reg.mode)
          AM_DIR_S, AM_BIT_D, AM_BITREL_D:
            r_next.ea = {PAGE_ZERO_HI, r_reg.b1};
          AM_DIR_L: r_next.ea = {r_reg.b1, r_reg.b2};
          AM_IND_S, AM_BIT_I, AM_BITREL_I:
            r_next.ea = {PAGE_ZERO_HI, r_reg.p1};
          AM_IND_L: r_next.ea = {r_reg.p1, r_reg.p2};
          AM_IDX_0, AM_IDX_S, AM_IDX_L, AM_IIDX_S, AM_IIDX_L:
            r_next.ea = idx_sum;
          AM_REL_D, AM_REL_I: r_next.ea = rel_sum;
          default: r_next.ea = '0;
        endcase
      end
    endcase
  end

  // Whole state in one register; reset returns to idle with outputs 0.
  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_reg <= AMD_STATE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Request is a level held until ack, so a slow memory just stretches
  // the fetch; a short mode thus costs fewer bus beats than a long one.
  assign mem_req_out = (r_reg.st == ST_OPND) || (r_reg.st == ST_PTR);
  assign mem_addr_out = r_reg.addr;
  assign dec_busy_out = (r_reg.st != ST_IDLE);
  assign dec_done_out = r_reg.done;
  assign dec_err_out = r_reg.err;
  assign dec_mode_out = r_reg.mode;
  assign dec_ea_out = r_reg.ea;
  assign dec_operand_out = r_reg.oper;
  assign dec_target_out = r_reg.target;
  assign dec_next_pc_out = r_reg.pc;
  assign dec_len_out = r_reg.len;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  chk_inh_no_fetch: assert property (
    (dec_start_in && !dec_busy_out && map.mode == AM_INH)
      |-> ##1 !mem_req_out ##1 (dec_done_out &&
           dec_len_out == {2'b00, $past(map.prefix_seen, 2)}))
    else $error("inherent mode fetched or finished late");

  chk_rmw_long_refused: assert property (
    (dec_start_in && !dec_busy_out && dec_rmw_in &&
     amd_is_long(map.mode))
      |=> (dec_done_out && dec_err_out && !dec_busy_out))
    else $error("long mode accepted for read-modify-write");

  chk_short_page_ea: assert property (
    (dec_done_out && !dec_err_out &&
     (dec_mode_out inside {AM_DIR_S, AM_IND_S, AM_BIT_D, AM_BIT_I,
                           AM_BITREL_D, AM_BITREL_I}))
      |-> dec_ea_out <= ZERO_PAGE_TOP)
    else $error("short mode address left the zero page");

  chk_idx_short_range: assert property (
    (dec_done_out && !dec_err_out && dec_mode_out == AM_IDX_S)
      |-> dec_ea_out <= IDX_SHORT_TOP)
    else $error("short indexed address above 1fe");

  chk_idx0_len: assert property (
    (dec_start_in && !dec_busy_out && map.mode == AM_IDX_0)
      |-> ##2 (dec_done_out &&
               dec_len_out == {2'b00, $past(map.prefix_seen, 2)}))
    else $error("no-offset indexed length wrong");

  chk_idx0_ea: assert property (
    (dec_start_in && !dec_busy_out && map.mode == AM_IDX_0 &&
     !map.use_y)
      |-> ##2 (dec_ea_out == {PAGE_ZERO_HI, $past(idx_x_in, 2)}))
    else $error("no-offset indexed address is not the index");

  chk_rel_reach: assert property (
    (dec_done_out && !dec_err_out &&
     (dec_mode_out inside {AM_REL_D, AM_REL_I}))
      |-> ($signed(dec_target_out - dec_next_pc_out) >= REL_MIN &&
           $signed(dec_target_out - dec_next_pc_out) <= REL_MAX))
    else $error("branch target outside the signed reach");

  chk_req_hold: assert property (
    (mem_req_out && !mem_ack_in) |=> (mem_req_out && $stable(mem_addr_out)))
    else $error("memory request dropped before ack");

  chk_word_order: assert property (
    (r_reg.st == ST_OPND && mem_ack_in && r_reg.cnt == '0 &&
     amd_opnd_bytes(r_reg.mode) == 2'h2)
      |=> (mem_addr_out == $past(mem_addr_out) + ADDR_STEP))
    else $error("second word byte not at the next address");

  chk_ptr_addr: assert property (
    (r_reg.st == ST_PTR && r_reg.cnt == '0)
      |-> mem_addr_out == {PAGE_ZERO_HI, r_reg.b1})
    else $error("pointer read not at the operand byte address");

  cov_long_indirect: cover property (
    dec_done_out && dec_mode_out == AM_IND_L);
  cov_bitrel_ind: cover property (
    dec_done_out && dec_mode_out == AM_BITREL_I);
  cov_rmw_err: cover property (dec_done_out && dec_err_out);
  cov_stall: cover property (mem_req_out && !mem_ack_in ##1 mem_ack_in);

endmodule

`default_nettype wire

// *** bench/amd_mem_model.sv ***
// Program and data memory seen by the addressing decoder.
// Assumes requests hold address until acked; ack is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none

module amd_mem_model (
  input wire logic clk_sys_in,
  input wire logic nrst_in,
  input wire logic mem_req_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic slow_in,
  output logic mem_ack_out,
  output logic [7:0] mem_rdata_out
);
  int fetches;
  int wait_cnt;

  // ----------------------------------------------------------------
  // Contents and answer
  // ----------------------------------------------------------------
  // Contents are a fixed function of the address, so no array is held.
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  // Data is only valid with ack; otherwise it toggles, so a decoder that
  // samples outside the ack cycle picks up garbage and is caught.
  always @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= 8'h00;
      fetches <= 0;
      wait_cnt <= 0;
    end else if (mem_ack_out) begin
      mem_ack_out <= 1'b0;
      mem_rdata_out <= ~mem_rdata_out;
      wait_cnt <= slow_in ? fetches % 3 : 0;
    end else if (mem_req_in && wait_cnt > 0) begin
      wait_cnt <= wait_cnt - 1;
      mem_rdata_out <= ~mem_rdata_out;
    end else if (mem_req_in) begin
      mem_ack_out <= 1'b1;
      mem_rdata_out <= byte_at(mem_addr_in);
      fetches <= fetches + 1;
    end else begin
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule

`default_nettype wire

// *** bench/tb_top.sv ***
// Testbench of the operand addressing decoder: corner and random cases,
// results compared with values worked out here from the inputs.
// Assumes the memory model in the same folder.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import amd_pkg::*;
  logic clk_sys_in = 1'b0;
  logic nrst_in = 1'b0;
  logic start = 1'b0;
  amd_mode_t mode_in = AM_INH;
  logic [7:0] pre = 8'h00;
  logic rmw = 1'b0;
  logic [15:0] pc = 16'h0000;
  logic [7:0] ix = 8'h00;
  logic [7:0] iy = 8'h00;
  logic slow = 1'b0;
  logic [7:0] rdata;
  logic ack, req, busy, done, err;
  logic [15:0] maddr, ea, target, npc;
  amd_mode_t mode_out;
  logic [7:0] oper;
  logic [2:0] len;
  int miscompares = 0;
  int checks_done = 0;
  int seed = 72809;
  amd_mode_t em;
  logic [15:0] e_ea, e_tg, e_np, pa;
  logic [7:0] b1, b2, p1, p2, e_ix, d;
  int e_ob, e_pb;
  logic e_err;

  always #4 clk_sys_in = ~clk_sys_in;

  amd_decoder amd_decoder_i (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .dec_start_in(start), .dec_mode_in(mode_in), .dec_prefix_in(pre),
    .dec_rmw_in(rmw), .dec_pc_in(pc), .idx_x_in(ix), .idx_y_in(iy),
    .mem_rdata_in(rdata), .mem_ack_in(ack), .mem_req_out(req),
    .mem_addr_out(maddr), .dec_busy_out(busy), .dec_done_out(done),
    .dec_err_out(err), .dec_mode_out(mode_out), .dec_ea_out(ea),
    .dec_operand_out(oper), .dec_target_out(target),
    .dec_next_pc_out(npc), .dec_len_out(len));

  amd_mem_model amd_mem_model_i (.clk_sys_in(clk_sys_in),
    .nrst_in(nrst_in), .mem_req_in(req), .mem_addr_in(maddr),
    .slow_in(slow), .mem_ack_out(ack), .mem_rdata_out(rdata));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] mb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wrap_up();
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Expected result of one instruction, using our own mapping table.
  task automatic calc(input amd_mode_t m, input logic [7:0] p);
    em = m;
    if (p == 8'h92 || p == 8'h91) begin
      case (m)
        AM_DIR_S: em = AM_IND_S;
        AM_DIR_L: em = AM_IND_L;
        AM_IDX_S: em = AM_IIDX_S;
        AM_IDX_L: em = AM_IIDX_L;
        AM_REL_D: em = AM_REL_I;
        AM_BIT_D: em = AM_BIT_I;
        AM_BITREL_D: em = AM_BITREL_I;
        default: em = m;
      endcase
    end
    if (p == 8'h91 && !(m inside {AM_IDX_S, AM_IDX_L})) em = m;
    e_ix = (p == 8'h90 || p == 8'h91) ? iy : ix;
    e_ob = (em inside {AM_INH, AM_IDX_0}) ? 0 :
      (em inside {AM_DIR_L, AM_IDX_L, AM_BITREL_D, AM_BITREL_I}) ? 2 : 1;
    e_pb = (em inside {AM_IND_L, AM_IIDX_L}) ? 2 :
      (em inside {AM_IND_S, AM_IIDX_S, AM_REL_I, AM_BIT_I, AM_BITREL_I});
    e_err = rmw && (em inside {AM_DIR_L, AM_IDX_L, AM_IND_L, AM_IIDX_L});
    b1 = mb(pc);
    b2 = mb(pc + 16'h0001);
    pa = {8'h00, b1};
    p1 = mb(pa);
    p2 = mb(pa + 16'h0001);
    e_np = pc + 16'(e_ob);
    d = (em == AM_REL_D) ? b1 : (em == AM_REL_I) ? p1 : b2;
    e_tg = (em inside {AM_REL_D, AM_REL_I, AM_BITREL_D, AM_BITREL_I}) ?
      e_np + {{8{d[7]}}, d} : e_np;
    case (em)
      AM_DIR_S, AM_BIT_D, AM_BITREL_D: e_ea = pa;
      AM_DIR_L: e_ea = {b1, b2};
      AM_IDX_0: e_ea = {8'h00, e_ix};
      AM_IDX_S: e_ea = pa + {8'h00, e_ix};
      AM_IDX_L: e_ea = {b1, b2} + {8'h00, e_ix};
      AM_IND_S, AM_BIT_I, AM_BITREL_I: e_ea = {8'h00, p1};
      AM_IND_L: e_ea = {p1, p2};
      AM_IIDX_S: e_ea = {8'h00, p1} + {8'h00, e_ix};
      AM_IIDX_L: e_ea = {p1, p2} + {8'h00, e_ix};
      AM_REL_D, AM_REL_I: e_ea = e_tg;
      default: e_ea = 16'h0000;
    endcase
  endtask

  // ----------------------------------------------------------------
  // One decode request, driven at rising edges, checked at falling ones
  // ----------------------------------------------------------------
  task automatic run_one(input amd_mode_t m, input logic [7:0] p,
      input logic r, input logic [15:0] a, input logic [7:0] x,
      input logic [7:0] y, input logic s);
    int n;
    int f0;
    logic bsy1;
    @(posedge clk_sys_in);
    mode_in <= m;
    pre <= p;
    rmw <= r;
    pc <= a;
    ix <= x;
    iy <= y;
    slow <= s;
    start <= 1'b1;
    @(posedge clk_sys_in);
    start <= 1'b0;
    f0 = amd_mem_model_i.fetches;
    calc(m, p);
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(negedge clk_sys_in);
      n++;
      if (n == 1) bsy1 = busy;
    end
    if (n >= 300) begin
      miscompares++;
      $display("mismatch at %0t: no done", $time);
      wrap_up();
    end else begin
      chk(16'(err), 16'(e_err));
      if (e_err) chk(16'(n), 16'h0001);
      if (e_err) chk(16'(amd_mem_model_i.fetches - f0), 16'h0000);
      chk(16'(bsy1), 16'(!e_err));
      if (!e_err) begin
        chk(16'(mode_out), 16'(em));
        chk(16'(len), 16'(e_ob) + 16'(p inside {8'h90, 8'h91, 8'h92}));
        chk(npc, e_np);
        chk(target, e_tg);
        chk(16'(oper), (em == AM_IMM) ? {8'h00, b1} : 16'h0000);
        if (em != AM_INH) chk(ea, e_ea);
        chk(16'(amd_mem_model_i.fetches - f0), 16'(e_ob + e_pb));
        if (e_ob + e_pb == 0) chk(16'(n), 16'h0002);
      end
      @(negedge clk_sys_in);
      chk(16'(done), 16'h0000);
      chk(16'(busy), 16'h0000);
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rnd;
    logic [31:0] rpc;
    repeat (6) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      run_one(amd_mode_t'(i), 8'h00, 1'b0, 16'h1234, 8'h21, 8'h43, 1'b1);
    end
    run_one(AM_IDX_S, 8'h00, 1'b0, 16'h00c3, 8'hff, 8'h00, 1'b0);
    run_one(AM_REL_D, 8'h00, 1'b0, 16'h00bc, 8'h00, 8'h00, 1'b0);
    run_one(AM_REL_D, 8'h00, 1'b0, 16'h0043, 8'h00, 8'h00, 1'b0);
    run_one(AM_IDX_0, 8'h90, 1'b0, 16'h0300, 8'h11, 8'hee, 1'b0);
    run_one(AM_IDX_S, 8'h91, 1'b0, 16'h0400, 8'h11, 8'hee, 1'b1);
    run_one(AM_IDX_L, 8'h92, 1'b0, 16'h0500, 8'h11, 8'hee, 1'b0);
    run_one(AM_REL_D, 8'h92, 1'b0, 16'h0600, 8'h00, 8'h00, 1'b0);
    run_one(AM_BITREL_D, 8'h92, 1'b0, 16'h0700, 8'h00, 8'h00, 1'b1);
    run_one(AM_DIR_L, 8'h00, 1'b1, 16'h0800, 8'h00, 8'h00, 1'b0);
    run_one(AM_IDX_L, 8'h92, 1'b1, 16'h0900, 8'h00, 8'h00, 1'b0);
    run_one(AM_DIR_S, 8'h00, 1'b1, 16'h0a00, 8'h00, 8'h00, 1'b0);
    for (int i = 0; i < 80; i++) begin
      rnd = $random(seed);
      rpc = $random(seed);
      run_one(amd_mode_t'(5'(rnd[31:20] % 12'd17)),
        rnd[17] ? 8'h90 : 8'h00, rnd[19:18] == 2'h3, rpc[15:0],
        rnd[7:0], rnd[15:8], rnd[16]);
    end
    wrap_up();
  end
endmodule

`default_nettype wire
